// file: common/mcd_map.svh
// Opcodes, field positions, reset values and constants of the decoder
`ifndef MCD_MAP_SVH
`define MCD_MAP_SVH
// ==========================================================
// Field positions inside the 14-bit instruction word; MCD_F_MSB is bit 15 of a data address
`define MCD_F_OP6     13:8
`define MCD_F_OP7     13:7
`define MCD_F_OP11    13:3
`define MCD_F_LIT8    7:0
`define MCD_F_LIT6    5:0
`define MCD_F_NSEL_K  6
`define MCD_F_NSEL_M  2
`define MCD_F_MM      1:0
`define MCD_F_MM_POST 1
`define MCD_F_MM_DEC  0
`define MCD_F_DBIT    7
`define MCD_F_FADDR   6:0
`define MCD_F_FPORT   6:1
`define MCD_F_FSEL    0
`define MCD_F_PORT_DIRECTION_REGISTER    2:0
`define MCD_F_MSB     15
// ==========================================================
// Full opcodes
`define MCD_OP_BRW    14'h000B
`define MCD_OP_CALL_VIA_ACCUM  14'h000A
`define MCD_OP_INTERRUPT_RETURN 14'h0009
`define MCD_OP_RETURN 14'h0008
`define MCD_OP_KICK   14'h0064
`define MCD_OP_OPTION 14'h0062
`define MCD_OP_RESET  14'h0001
`define MCD_OP_SLEEP  14'h0063
// ==========================================================
// Opcode prefixes
`define MCD_PX_RETURN_WITH_LITERAL  6'h34
`define MCD_PX_AND_LITERAL  6'h39
`define MCD_PX_ADD_LITERAL  6'h3E
`define MCD_PX_AND_ACCUM_FILE  6'h05
`define MCD_PX_POINTER_ADD_LITERAL 7'h62
`define MCD_PX_LDIDX  7'h7E
`define MCD_PX_STIDX  7'h7F
`define MCD_PX_LDMOD  11'h002
`define MCD_PX_STMOD  11'h003
`define MCD_PX_PORT_DIRECTION_REGISTER   11'h00C
`define MCD_PORT_IND  6'h00
// ==========================================================
// Reset values and small constants
`define MCD_PC_RST    15'h0000
`define MCD_W_RST     8'h00
`define MCD_PTR_RST   16'h0000
`define MCD_SP_RST    4'h0
`define MCD_SP_ONE    4'h1
`define MCD_BYTE_RST  8'h00
`define MCD_PC_ONE    15'h0001
`define MCD_K_INC     6'h01
`define MCD_K_DEC     6'h3F
`define MCD_BANK_PAD  4'h0
`define MCD_STACK_N   16
`endif

// file: common/mcd_pkg.sv
// Types shared by the decoder modules
`default_nettype none
package mcd_pkg;
  // ==========================================================
  // Execution sequencer states
  typedef enum logic [1:0] {MCD_EXEC, MCD_FLUSH, MCD_EXTRA} mcd_state_t;
  // ALU operation select
  typedef enum logic {MCD_ALU_AND, MCD_ALU_ADD} mcd_alu_op_t;
  // Deferred data access kind
  typedef enum logic [1:0] {MCD_PD_LOAD, MCD_PD_STORE, MCD_PD_AND_W, MCD_PD_AND_F} mcd_pend_t;
endpackage
`default_nettype wire

// file: design/mcd_alu.sv
// Byte ALU for AND and add with status flags
`default_nettype none
`include "mcd_map.svh"
module mcd_alu (
  input  wire logic [7:0]          a,
  input  wire logic [7:0]          b,
  input  wire mcd_pkg::mcd_alu_op_t op,
  output logic      [7:0]          result,
  output logic                     carry,
  output logic                     half_carry,
  output logic                     zero
);
  logic [8:0] sum;
  logic [4:0] low_sum;

  // ==========================================================
  // Add and AND datapaths
  assign sum     = {1'b0, a} + {1'b0, b};
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]};
  assign result  = (op == mcd_pkg::MCD_ALU_ADD) ? sum[7:0] : (a & b);
  assign carry      = sum[8];
  assign half_carry = low_sum[4];
  assign zero       = (result == `MCD_BYTE_RST);
endmodule
`default_nettype wire

// file: design/mcd_decode.sv
// Instruction decoder and executor for control, pointer and literal ops
`default_nettype none
`include "mcd_map.svh"
module mcd_decode (
  input  wire logic        clk,
  input  wire logic        rst_n,
  output logic [14:0]      prog_addr,
  input  wire logic [13:0] instr_word,
  input  wire logic [6:0]  pclath_in,
  input  wire logic [4:0]  bank_in,
  output logic [15:0]      data_addr,
  output logic             data_rd_en,
  output logic             data_wr_en,
  output logic [7:0]       data_wdata,
  input  wire logic [7:0]  data_rdata,
  output logic [7:0]       accum,
  output logic [15:0]      pointer0,
  output logic [15:0]      pointer1,
  output logic             carry_flag,
  output logic             half_carry_flag,
  output logic             zero_flag,
  output logic             watchdog_expiry_flag,
  output logic             low_power_entry_flag,
  output logic [7:0]       option_value,
  output logic             dir_wr,
  output logic [2:0]       dir_sel,
  output logic [7:0]       dir_value,
  output logic             watchdog_clear,
  output logic             soft_reset,
  output logic             sleep_entry,
  output logic             interrupt_return
);
  // ==========================================================
  // State
  mcd_pkg::mcd_state_t  state_reg, state_next;
  mcd_pkg::mcd_pend_t   pend_reg, pend_next;
  logic [14:0]          pc_reg, pc_next;
  logic [7:0]           w_reg, w_next;
  logic [15:0]          ptr_reg [0:1];
  logic [15:0]          ptr_next [0:1];
  logic [14:0]          stack_reg [0:`MCD_STACK_N-1];
  logic [3:0]           sp_reg;
  logic                 push, pop;
  logic [15:0]          pend_addr_reg, pend_addr_next;
  logic                 c_reg, c_next, dc_reg, dc_next, z_reg, z_next;
  logic                 to_reg, to_next, pd_reg, pd_next;
  logic [7:0]           opt_reg;
  logic                 opt_wr;
  logic                 dir_wr_reg, dir_wr_next;
  logic [2:0]           dir_sel_reg;
  logic [7:0]           dir_val_reg;
  logic                 kick_reg, kick_next, rst_reg, rst_next;
  logic                 slp_reg, slp_next, iret_reg, iret_next;
  logic [7:0]           alu_b, alu_res;
  mcd_pkg::mcd_alu_op_t alu_op;
  logic                 alu_c, alu_dc, alu_z;
  logic [13:0]          ir;
  logic [15:0]          ea;
  logic                 n_sel;

  // Pointer plus signed 6-bit literal, wrapping in 16 bits
  function automatic logic [15:0] ptr_ofs(input logic [15:0] p, input logic [5:0] k);
    ptr_ofs = p + {{10{k[5]}}, k};
  endfunction

  // Start a data access; pointer MSB set defers it one cycle
  function automatic logic needs_extra(input logic [15:0] a, input logic via_ptr);
    needs_extra = via_ptr & a[`MCD_F_MSB];
  endfunction

  // ==========================================================
  // Shared ALU
  mcd_alu u_alu (
    .a          (w_reg),
    .b          (alu_b),
    .op         (alu_op),
    .result     (alu_res),
    .carry      (alu_c),
    .half_carry (alu_dc),
    .zero       (alu_z)
  );

  assign ir = instr_word;

  // ==========================================================
  // Decode and next-state logic
  always_comb
  begin
    state_next     = mcd_pkg::MCD_EXEC;
    pend_next      = pend_reg;
    pend_addr_next = pend_addr_reg;
    pc_next        = pc_reg + `MCD_PC_ONE;
    w_next         = w_reg;
    ptr_next[0]    = ptr_reg[0];
    ptr_next[1]    = ptr_reg[1];
    push           = 1'b0;
    pop            = 1'b0;
    c_next         = c_reg;
    dc_next        = dc_reg;
    z_next         = z_reg;
    to_next        = to_reg;
    pd_next        = pd_reg;
    opt_wr         = 1'b0;
    dir_wr_next    = 1'b0;
    kick_next      = 1'b0;
    rst_next       = 1'b0;
    slp_next       = 1'b0;
    iret_next      = 1'b0;
    alu_b          = data_rdata;
    alu_op         = mcd_pkg::MCD_ALU_AND;
    data_addr      = pend_addr_reg;
    data_rd_en     = 1'b0;
    data_wr_en     = 1'b0;
    data_wdata     = w_reg;
    ea             = `MCD_PTR_RST;
    n_sel          = 1'b0;
    case (state_reg)
      mcd_pkg::MCD_FLUSH:
      begin
        // Second cycle of a PC change runs as a no-op
        pc_next = pc_reg;
      end
      mcd_pkg::MCD_EXTRA:
      begin
        // Deferred access through a high pointer completes here
        data_rd_en = (pend_reg != mcd_pkg::MCD_PD_STORE);
        data_wr_en = (pend_reg == mcd_pkg::MCD_PD_STORE);
        case (pend_reg)
          mcd_pkg::MCD_PD_LOAD:
          begin
            w_next = data_rdata;
            z_next = (data_rdata == `MCD_BYTE_RST);
          end
          mcd_pkg::MCD_PD_AND_W:
          begin
            w_next = alu_res;
            z_next = alu_z;
          end
          mcd_pkg::MCD_PD_AND_F:
          begin
            data_wr_en = 1'b1;
            data_wdata = alu_res;
            z_next     = alu_z;
          end
          default:
          begin
            data_wdata = w_reg;
          end
        endcase
      end
      default:
      begin
        if (ir == `MCD_OP_BRW)
        begin
          pc_next    = pc_reg + `MCD_PC_ONE + {7'h00, w_reg};
          state_next = mcd_pkg::MCD_FLUSH;
        end
        else if (ir == `MCD_OP_CALL_VIA_ACCUM)
        begin
          push       = 1'b1;
          pc_next    = {pclath_in, w_reg};
          state_next = mcd_pkg::MCD_FLUSH;
        end
        else if (ir == `MCD_OP_INTERRUPT_RETURN)
        begin
          pop        = 1'b1;
          iret_next  = 1'b1;
          pc_next    = stack_reg[sp_reg - `MCD_SP_ONE];
          state_next = mcd_pkg::MCD_FLUSH;
        end
        else if (ir == `MCD_OP_RETURN)
        begin
          pop        = 1'b1;
          pc_next    = stack_reg[sp_reg - `MCD_SP_ONE];
          state_next = mcd_pkg::MCD_FLUSH;
        end
        else if (ir[`MCD_F_OP6] == `MCD_PX_RETURN_WITH_LITERAL)
        begin
          pop        = 1'b1;
          w_next     = ir[`MCD_F_LIT8];
          pc_next    = stack_reg[sp_reg - `MCD_SP_ONE];
          state_next = mcd_pkg::MCD_FLUSH;
        end
        else if (ir == `MCD_OP_KICK)
        begin
          kick_next = 1'b1;
          to_next   = 1'b1;
          pd_next   = 1'b1;
        end
        else if (ir == `MCD_OP_OPTION)
          opt_wr = 1'b1;
        else if (ir == `MCD_OP_RESET)
          rst_next = 1'b1;
        else if (ir == `MCD_OP_SLEEP)
        begin
          slp_next  = 1'b1;
          kick_next = 1'b1;
          to_next   = 1'b1;
          pd_next   = 1'b0;
        end
        else if (ir[`MCD_F_OP11] == `MCD_PX_PORT_DIRECTION_REGISTER)
          dir_wr_next = 1'b1;
        else if (ir[`MCD_F_OP7] == `MCD_PX_POINTER_ADD_LITERAL)
        begin
          n_sel           = ir[`MCD_F_NSEL_K];
          ptr_next[n_sel] = ptr_ofs(ptr_reg[n_sel], ir[`MCD_F_LIT6]);
        end
        else if (ir[`MCD_F_OP11] == `MCD_PX_LDMOD || ir[`MCD_F_OP11] == `MCD_PX_STMOD)
        begin
          // Pre-modify uses the new pointer, post-modify the old one
          n_sel           = ir[`MCD_F_NSEL_M];
          ptr_next[n_sel] = ptr_ofs(ptr_reg[n_sel], ir[`MCD_F_MM_DEC] ? `MCD_K_DEC : `MCD_K_INC);
          ea              = ir[`MCD_F_MM_POST] ? ptr_reg[n_sel] : ptr_next[n_sel];
          pend_next       = (ir[`MCD_F_OP11] == `MCD_PX_LDMOD) ? mcd_pkg::MCD_PD_LOAD : mcd_pkg::MCD_PD_STORE;
        end
        else if (ir[`MCD_F_OP7] == `MCD_PX_LDIDX || ir[`MCD_F_OP7] == `MCD_PX_STIDX)
        begin
          n_sel     = ir[`MCD_F_NSEL_K];
          ea        = ptr_ofs(ptr_reg[n_sel], ir[`MCD_F_LIT6]);
          pend_next = (ir[`MCD_F_OP7] == `MCD_PX_LDIDX) ? mcd_pkg::MCD_PD_LOAD : mcd_pkg::MCD_PD_STORE;
        end
        else if (ir[`MCD_F_OP6] == `MCD_PX_AND_LITERAL)
        begin
          alu_b  = ir[`MCD_F_LIT8];
          w_next = alu_res;
          z_next = alu_z;
        end
        else if (ir[`MCD_F_OP6] == `MCD_PX_ADD_LITERAL)
        begin
          alu_b   = ir[`MCD_F_LIT8];
          alu_op  = mcd_pkg::MCD_ALU_ADD;
          w_next  = alu_res;
          c_next  = alu_c;
          dc_next = alu_dc;
          z_next  = alu_z;
        end
        else if (ir[`MCD_F_OP6] == `MCD_PX_AND_ACCUM_FILE)
        begin
          // Addresses 0 and 1 are the indirect data ports
          if (ir[`MCD_F_FPORT] == `MCD_PORT_IND)
            ea = ptr_reg[ir[`MCD_F_FSEL]];
          else
            ea = {`MCD_BANK_PAD, bank_in, ir[`MCD_F_FADDR]};
          pend_next = ir[`MCD_F_DBIT] ? mcd_pkg::MCD_PD_AND_F : mcd_pkg::MCD_PD_AND_W;
        end
        // Common data access for pointer and file operations
        if (ir[`MCD_F_OP11] == `MCD_PX_LDMOD || ir[`MCD_F_OP11] == `MCD_PX_STMOD
            || ir[`MCD_F_OP7] == `MCD_PX_LDIDX || ir[`MCD_F_OP7] == `MCD_PX_STIDX
            || ir[`MCD_F_OP6] == `MCD_PX_AND_ACCUM_FILE)
        begin
          pend_addr_next = ea;
          data_addr      = ea;
          if (needs_extra(ea, ir[`MCD_F_OP6] != `MCD_PX_AND_ACCUM_FILE || ir[`MCD_F_FPORT] == `MCD_PORT_IND))
          begin
            pc_next    = pc_reg;
            state_next = mcd_pkg::MCD_EXTRA;
          end
          else
          begin
            data_rd_en = (pend_next != mcd_pkg::MCD_PD_STORE);
            data_wr_en = (pend_next == mcd_pkg::MCD_PD_STORE) || (pend_next == mcd_pkg::MCD_PD_AND_F);
            data_wdata = (pend_next == mcd_pkg::MCD_PD_STORE) ? w_reg : alu_res;
            if (pend_next == mcd_pkg::MCD_PD_LOAD)
            begin
              w_next = data_rdata;
              z_next = (data_rdata == `MCD_BYTE_RST);
            end
            else if (pend_next != mcd_pkg::MCD_PD_STORE)
            begin
              z_next = alu_z;
              if (pend_next == mcd_pkg::MCD_PD_AND_W)
                w_next = alu_res;
            end
          end
        end
      end
    endcase
  end

  // ==========================================================
  // Sequencer, program counter and pending access
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg     <= mcd_pkg::MCD_EXEC;
      pend_reg      <= mcd_pkg::MCD_PD_LOAD;
      pend_addr_reg <= `MCD_PTR_RST;
      pc_reg        <= `MCD_PC_RST;
    end
    else
    begin
      state_reg     <= state_next;
      pend_reg      <= pend_next;
      pend_addr_reg <= pend_addr_next;
      pc_reg        <= pc_next;
    end
  end

  // Return stack, wraps on over- and underflow
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sp_reg <= `MCD_SP_RST;
    else if (push)
    begin
      stack_reg[sp_reg] <= pc_reg + `MCD_PC_ONE;
      sp_reg            <= sp_reg + `MCD_SP_ONE;
    end
    else if (pop)
      sp_reg <= sp_reg - `MCD_SP_ONE;
  end

  // Accumulator, pointers and status flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      w_reg      <= `MCD_W_RST;
      ptr_reg[0] <= `MCD_PTR_RST;
      ptr_reg[1] <= `MCD_PTR_RST;
      c_reg      <= 1'b0;
      dc_reg     <= 1'b0;
      z_reg      <= 1'b0;
      to_reg     <= 1'b1;
      pd_reg     <= 1'b1;
    end
    else
    begin
      w_reg      <= w_next;
      ptr_reg[0] <= ptr_next[0];
      ptr_reg[1] <= ptr_next[1];
      c_reg      <= c_next;
      dc_reg     <= dc_next;
      z_reg      <= z_next;
      to_reg     <= to_next;
      pd_reg     <= pd_next;
    end
  end

  // Option and direction register loads
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      opt_reg     <= `MCD_BYTE_RST;
      dir_wr_reg  <= 1'b0;
      dir_sel_reg <= 3'h0;
      dir_val_reg <= `MCD_BYTE_RST;
    end
    else
    begin
      dir_wr_reg <= dir_wr_next;
      if (opt_wr)
        opt_reg <= w_reg;
      if (dir_wr_next)
      begin
        dir_sel_reg <= ir[`MCD_F_PORT_DIRECTION_REGISTER];
        dir_val_reg <= w_reg;
      end
    end
  end

  // One-cycle event pulses
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      kick_reg <= 1'b0;
      rst_reg  <= 1'b0;
      slp_reg  <= 1'b0;
      iret_reg <= 1'b0;
    end
    else
    begin
      kick_reg <= kick_next;
      rst_reg  <= rst_next;
      slp_reg  <= slp_next;
      iret_reg <= iret_next;
    end
  end

  // ==========================================================
  // Outputs
  assign prog_addr            = pc_reg;
  assign accum                = w_reg;
  assign pointer0             = ptr_reg[0];
  assign pointer1             = ptr_reg[1];
  assign carry_flag           = c_reg;
  assign half_carry_flag      = dc_reg;
  assign zero_flag            = z_reg;
  assign watchdog_expiry_flag = to_reg;
  assign low_power_entry_flag = pd_reg;
  assign option_value         = opt_reg;
  assign dir_wr               = dir_wr_reg;
  assign dir_sel              = dir_sel_reg;
  assign dir_value            = dir_val_reg;
  assign watchdog_clear       = kick_reg;
  assign soft_reset           = rst_reg;
  assign sleep_entry          = slp_reg;
  assign interrupt_return     = iret_reg;
endmodule
`default_nettype wire

// file: dv/mcd_decode_asserts.sv
// Concurrent checks on the decoder's ports
`default_nettype none
module mcd_decode_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [14:0] prog_addr,
  input wire logic [15:0] data_addr,
  input wire logic        data_rd_en,
  input wire logic        data_wr_en,
  input wire logic [7:0]  data_wdata,
  input wire logic [7:0]  accum,
  input wire logic        watchdog_expiry_flag,
  input wire logic        low_power_entry_flag,
  input wire logic [7:0]  option_value,
  input wire logic        dir_wr,
  input wire logic [7:0]  dir_value,
  input wire logic        watchdog_clear,
  input wire logic        soft_reset,
  input wire logic        sleep_entry,
  input wire logic        interrupt_return
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Flush cycle: program address held one more cycle
  sequence s_held;
    ##1 $stable(prog_addr);
  endsequence
  sequence s_iret_done;
    ##1 (!interrupt_return && $stable(prog_addr));
  endsequence
  property p_pc_hold;
    (prog_addr != $past(prog_addr) + 15'h0001) && (prog_addr != $past(prog_addr)) |-> s_held;
  endproperty
  property p_extra;
    (data_rd_en || data_wr_en) && data_addr[15] |-> prog_addr == $past(prog_addr);
  endproperty
  property p_iret;
    interrupt_return |-> s_iret_done;
  endproperty
  property p_kick;
    watchdog_clear && !sleep_entry |-> watchdog_expiry_flag && low_power_entry_flag;
  endproperty
  property p_sleep;
    sleep_entry |-> watchdog_clear && watchdog_expiry_flag && !low_power_entry_flag ##1 !sleep_entry;
  endproperty
  property p_opt;
    $changed(option_value) |-> option_value == accum;
  endproperty
  property p_dir;
    dir_wr |-> dir_value == accum;
  endproperty
  property p_rst;
    $rose(soft_reset) |=> $fell(soft_reset);
  endproperty
  property p_store;
    data_wr_en && !data_rd_en |-> data_wdata == accum;
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("no flush after jump");
  a_extra: assert property (p_extra) else $error("no extra cycle");
  a_iret: assert property (p_iret) else $error("interrupt return misbehaves");
  a_kick: assert property (p_kick) else $error("kick flags wrong");
  a_sleep: assert property (p_sleep) else $error("sleep flags wrong");
  a_opt: assert property (p_opt) else $error("option not accumulator");
  a_dir: assert property (p_dir) else $error("direction value wrong");
  a_rst: assert property (p_rst) else $error("soft reset pulse length");
  a_store: assert property (p_store) else $error("store data wrong");
endmodule
bind mcd_decode mcd_decode_chk u_chk (.clk(clk), .rst_n(rst_n), .prog_addr(prog_addr),
  .data_addr(data_addr), .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .data_wdata(data_wdata),
  .accum(accum), .watchdog_expiry_flag(watchdog_expiry_flag), .low_power_entry_flag(low_power_entry_flag),
  .option_value(option_value), .dir_wr(dir_wr), .dir_value(dir_value), .watchdog_clear(watchdog_clear),
  .soft_reset(soft_reset), .sleep_entry(sleep_entry), .interrupt_return(interrupt_return));
`default_nettype wire

// file: dv/mcd_mem.sv
// Program and data memory model facing the decoder
`default_nettype none
module mcd_mem (
  input  wire logic        clk,
  input  wire logic [14:0] prog_addr,
  output logic      [13:0] instr_word,
  input  wire logic [15:0] data_addr,
  input  wire logic        data_rd_en,
  input  wire logic        data_wr_en,
  input  wire logic [7:0]  data_wdata,
  output logic      [7:0]  data_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [13:0] rom [0:511];
  logic [7:0]  ram [0:255];
  logic [7:0]  junk_reg = 8'h3C;
  // Word at the program address in the same cycle
  assign instr_word = rom[prog_addr[8:0]];
  // Read data only while selected, otherwise a moving pattern
  assign data_rdata = data_rd_en ? ram[data_addr[7:0]] : junk_reg;
  // Write at the edge; idle pattern changes every cycle
  always @(posedge clk)
  begin
    junk_reg <= ~junk_reg ^ 8'h5A;
    if (data_wr_en)
      ram[data_addr[7:0]] <= data_wdata;
  end
endmodule
`default_nettype wire

// file: dv/tb_top.sv
// Self-checking bench for the instruction decoder
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst_n, data_rd_en, data_wr_en, carry_flag, half_carry_flag, zero_flag;
  logic        watchdog_expiry_flag, low_power_entry_flag, dir_wr, watchdog_clear;
  logic        soft_reset, sleep_entry, interrupt_return;
  logic [14:0] prog_addr;
  logic [13:0] instr_word;
  logic [6:0]  pclath_in;
  logic [4:0]  bank_in;
  logic [2:0]  dir_sel;
  logic [15:0] data_addr, pointer0, pointer1;
  logic [7:0]  data_wdata, data_rdata, accum, option_value, dir_value;
  int          mismatches, num_checks;
  // Program from address 0, one word per entry
  localparam logic [13:0] PROG [0:31] = '{14'h3E05, 14'h000B, 14'h0000, 14'h0000, 14'h0000, 14'h0000,
    14'h0000, 14'h3EFB, 14'h393C, 14'h3E0C, 14'h0062, 14'h0065, 14'h313F, 14'h315F, 14'h0017,
    14'h001D, 14'h3F43, 14'h3EF3, 14'h05A2, 14'h0523, 14'h3F80, 14'h3E2A, 14'h000A, 14'h0064,
    14'h0063, 14'h0064, 14'h0001, 14'h3E11, 14'h000A, 14'h3E01, 14'h000A, 14'h0000};
  mcd_decode dut (
    .clk(clk), .rst_n(rst_n), .prog_addr(prog_addr), .instr_word(instr_word), .pclath_in(pclath_in),
    .bank_in(bank_in), .data_addr(data_addr), .data_rd_en(data_rd_en), .data_wr_en(data_wr_en),
    .data_wdata(data_wdata), .data_rdata(data_rdata), .accum(accum), .pointer0(pointer0),
    .pointer1(pointer1), .carry_flag(carry_flag), .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .watchdog_expiry_flag(watchdog_expiry_flag), .low_power_entry_flag(low_power_entry_flag),
    .option_value(option_value), .dir_wr(dir_wr), .dir_sel(dir_sel), .dir_value(dir_value),
    .watchdog_clear(watchdog_clear), .soft_reset(soft_reset), .sleep_entry(sleep_entry),
    .interrupt_return(interrupt_return));
  mcd_mem mem (
    .clk(clk), .prog_addr(prog_addr), .instr_word(instr_word), .data_addr(data_addr),
    .data_rd_en(data_rd_en), .data_wr_en(data_wr_en), .data_wdata(data_wdata), .data_rdata(data_rdata));
  // ==========================================================
  // Compare, verdict and step helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Count edges until the program address lands on a, then check the count
  task automatic go(input logic [14:0] a, input logic [15:0] n);
    logic [15:0] c;
    c = 16'h0000;
    do
    begin
      @(negedge clk);
      c = c + 16'h0001;
    end
    while (prog_addr !== a && c < 16'h0010);
    chk(c, n);
  endtask
  // Clock source
  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    repeat (500) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
  // Main sequence
  initial
  begin
    mismatches = 0;
    num_checks = 0;
    rst_n = 1'h0;
    pclath_in = 7'h01;
    bank_in = 5'h01;
    for (int i = 0; i < 512; i++)
      mem.rom[i] = (i < 32) ? PROG[i] : 14'h0000;
    for (int i = 0; i < 256; i++)
      mem.ram[i] = 8'h00;
    mem.rom[9'h12A] = 14'h3407;
    mem.rom[9'h118] = 14'h0008;
    mem.rom[9'h119] = 14'h0009;
    mem.ram[8'h1F] = 8'h81;
    mem.ram[8'hA2] = 8'h3C;
    mem.ram[8'hA3] = 8'h0C;
    mem.ram[8'hFF] = 8'h55;
    repeat (20) @(negedge clk);
    chk({accum, pointer0, watchdog_expiry_flag, low_power_entry_flag}, {8'h00, 16'h0000, 2'h3});
    rst_n = 1'h1;
    go(15'h001, 16'h0001); chk(accum, 8'h05);
    go(15'h007, 16'h0001);
    go(15'h008, 16'h0002);
    chk({accum, carry_flag, half_carry_flag, zero_flag}, {8'h00, 3'h7});
    go(15'h009, 16'h0001); chk({accum, carry_flag, zero_flag}, {8'h00, 2'h3});
    go(15'h00A, 16'h0001); chk({accum, carry_flag, half_carry_flag, zero_flag}, {8'h0C, 3'h0});
    go(15'h00B, 16'h0001); chk(option_value, 8'h0C);
    go(15'h00C, 16'h0001); chk({dir_wr, dir_sel, dir_value}, {1'h1, 3'h5, 8'h0C});
    go(15'h00D, 16'h0001); chk(pointer0, 16'hFFFF);
    go(15'h00E, 16'h0001); chk({pointer1, carry_flag, zero_flag}, {16'h001F, 2'h0});
    go(15'h00F, 16'h0001); chk({accum, pointer1, zero_flag}, {8'h81, 16'h001E, 1'h0});
    go(15'h010, 16'h0001); chk({pointer1, mem.ram[8'h1D]}, {16'h001D, 8'h81});
    go(15'h011, 16'h0001); chk({accum, zero_flag}, {8'h00, 1'h1});
    go(15'h012, 16'h0001);
    go(15'h013, 16'h0001); chk({accum, zero_flag, mem.ram[8'hA2]}, {8'hF3, 1'h0, 8'h30});
    go(15'h014, 16'h0001); chk({accum, zero_flag}, {8'h00, 1'h1});
    go(15'h015, 16'h0002); chk(mem.ram[8'hFF], 8'h00);
    go(15'h016, 16'h0001);
    go(15'h12A, 16'h0001);
    go(15'h017, 16'h0002); chk(accum, 8'h07);
    go(15'h018, 16'h0002); chk({watchdog_clear, watchdog_expiry_flag, low_power_entry_flag}, 3'h7);
    go(15'h019, 16'h0001); chk({sleep_entry, watchdog_expiry_flag, low_power_entry_flag}, 3'h6);
    go(15'h01A, 16'h0001); chk(low_power_entry_flag, 1'h1);
    go(15'h01B, 16'h0001); chk(soft_reset, 1'h1);
    go(15'h01C, 16'h0001);
    go(15'h118, 16'h0001);
    go(15'h01D, 16'h0002);
    go(15'h01E, 16'h0002); chk(accum, 8'h19);
    go(15'h119, 16'h0001);
    go(15'h01F, 16'h0002); chk(interrupt_return, 1'h1);
    go(15'h020, 16'h0002);
    tally_and_finish();
  end
endmodule
`default_nettype wire
